// ### src/edge_capture_pkg.sv
package edge_capture_pkg;

   // Register word indices, not byte addresses (byte address = index*4)
   localparam logic [7:0] idx_cap0_rise    = 8'h22;
   localparam logic [7:0] idx_cap1_rise    = 8'h23;
   localparam logic [7:0] idx_cap0_fall    = 8'h24;
   localparam logic [7:0] idx_cap1_fall    = 8'h25;
   localparam logic [7:0] idx_count_low    = 8'h26;
   localparam logic [7:0] idx_count_high   = 8'h27;
   localparam logic [7:0] idx_reload_low   = 8'h28;
   localparam logic [7:0] idx_reload_high  = 8'h29;
   localparam logic [7:0] idx_timer_config = 8'h2a;
   localparam logic [7:0] idx_irq_enable   = 8'h2b;
   localparam logic [7:0] idx_irq_status   = 8'h2c;

   // Timer configuration fields
   localparam int cfg_hold_bit     = 7;
   localparam int cfg_prescale_lsb = 4;
   localparam int cfg_wide_bit     = 3;

   // Capture source bit positions in enable and status
   localparam int src_c0_rise = 0;
   localparam int src_c0_fall = 1;
   localparam int src_c1_rise = 2;
   localparam int src_c1_fall = 3;

   // Reset values
   localparam logic [7:0]  byte_reset   = 8'h00;
   localparam logic [11:0] reload_reset = 12'h000;

   // AXI responses
   localparam logic [1:0] resp_okay   = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;

   // Per-source capture event bundle
   typedef struct packed {
      logic [3:0] load;
      logic [3:0] edge_seen;
   } capture_event_t;

endpackage : edge_capture_pkg

// ### src/edge_capture_and_interval_timer.sv
`timescale 1ns/1ps

module edge_capture_and_interval_timer #(
   parameter int timer_width = 16,
   parameter int count_width = 12
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Time base from the free-running counter
   input  wire logic [15:0] free_timer,
   input  wire logic        timer_tick,
   // Capture pins
   input  wire logic        capture_input_zero,
   input  wire logic        capture_input_one,
   // Interrupt requests
   output logic [3:0]       capture_irq,
   output logic             interval_irq,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import edge_capture_pkg::*;

   // Register map, as seen by software (byte address = 4 * word index):
   //   0x88 capture0_rise_time    read only, channel zero rise time
   //   0x8c capture1_rise_time    read only, channel one rise time or wide upper byte
   //   0x90 capture0_fall_time    read only, channel zero fall time
   //   0x94 capture1_fall_time    read only, channel one fall time or wide upper byte
   //   0x98 interval_count_low    read only, live low byte, latches the upper nibble
   //   0x9c interval_count_high   read only, nibble latched at the last low-byte read
   //   0xa0 interval_reload_low   read/write, reload bits 7..0
   //   0xa4 interval_reload_high  read/write, reload bits 11..8 in bits 3..0
   //   0xa8 timer_config          read/write, hold-first, prescale, wide mode
   //   0xac capture_irq_enable    read/write, one enable per capture source
   //   0xb0 capture_irq_status    write one to clear, one flag per capture source
   // Only byte lane zero carries register data; the upper read lanes are zero.
   // Addresses outside the map answer with an error code and change nothing.
   // Writes to the read-only places answer okay and are dropped, so firmware
   // that walks the map with writes does not trip a bus error.
   //
   // Bus timing:
   //   Write address and data are held in their own slots and may come in
   //   either order; the response is raised the cycle after both slots fill.
   //   A read is answered the cycle after its address is taken, with data
   //   from flip-flops so the read path never sees a combinational loop.
   //   Only one write and one read are in flight; readies drop meanwhile.
   //
   // Capture timing:
   //   A pin level that differs from the level one edge earlier is an edge.
   //   The time base value present at that same edge is stored, so a pin
   //   change is seen one cycle after it appears on the pin.
   //   Pins are taken as already synchronous; an asynchronous source must
   //   be synchronised outside this block or captures may go metastable.
   //
   // Interval timer:
   //   The count moves only on timer_tick; a tick at zero reloads and
   //   raises the one-cycle interval request on the following cycle.
   //   Each reload byte takes effect when written, so a reload that lands
   //   between the two writes uses the new low byte with the old high nibble.

   // The selection logic is written for these widths only
   if (timer_width != 16 || count_width != 12) begin : g_bad_width
      $error("edge_capture_and_interval_timer supports only 16/12 bit widths");
   end

   // Word index of an AXI byte address
   function automatic logic [7:0] word_index(input logic [7:0] addr);
      return {2'b00, addr[7:2]};
   endfunction : word_index

   // Register state
   logic [7:0]  cap_time [4];
   logic [3:0]  cap_read_since;
   logic [3:0]  irq_enable;
   logic [3:0]  irq_status;
   logic [7:0]  timer_config;
   logic [11:0] reload;
   logic [11:0] count;
   logic [3:0]  count_high_hold;
   logic        in0_q;
   logic        in1_q;

   // Write channel holding: address and data may arrive in either order
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   // Configuration decode
   wire         hold_first   = timer_config[cfg_hold_bit];
   wire         wide_mode    = timer_config[cfg_wide_bit];
   wire [2:0]   prescale     = timer_config[cfg_prescale_lsb +: 3];

   // Edge detection on the pins, taken as synchronous to aclk
   wire         rise0 = capture_input_zero & ~in0_q;
   wire         fall0 = ~capture_input_zero & in0_q;
   wire         rise1 = capture_input_one & ~in1_q & ~wide_mode;
   wire         fall1 = ~capture_input_one & in1_q & ~wide_mode;

   // Timer byte choice: prescaled window in eight-bit mode, low byte for channel zero and high byte for channel one in wide mode
   wire [15:0]  timer_shifted = free_timer >> prescale;
   wire [7:0]   narrow_byte   = timer_shifted[7:0];
   wire [7:0]   chan0_byte    = wide_mode ? free_timer[7:0] : narrow_byte;
   wire [7:0]   chan1_byte    = wide_mode ? free_timer[15:8] : narrow_byte;

   // Which edge each source register follows
   wire [3:0]   src_edge;
   assign src_edge[src_c0_rise] = rise0;
   assign src_edge[src_c0_fall] = fall0;
   assign src_edge[src_c1_rise] = wide_mode ? rise0 : rise1;
   assign src_edge[src_c1_fall] = wide_mode ? fall0 : fall1;

   // Hold-first blocks loads until software has read the register
   capture_event_t ev;
   assign ev.edge_seen = src_edge;
   assign ev.load      = src_edge & (hold_first ? cap_read_since : 4'hf);

   wire [7:0]   src_byte [4];
   assign src_byte[src_c0_rise] = chan0_byte;
   assign src_byte[src_c0_fall] = chan0_byte;
   assign src_byte[src_c1_rise] = chan1_byte;
   assign src_byte[src_c1_fall] = chan1_byte;

   // AXI handshake decode
   wire         aw_take   = s_axi_awvalid & s_axi_awready;
   wire         w_take    = s_axi_wvalid & s_axi_wready;
   wire         wr_fire   = aw_held & w_held & ~s_axi_bvalid;
   wire         rd_take   = s_axi_arvalid & s_axi_arready;
   wire [7:0]   wr_index  = word_index(aw_addr);
   wire [7:0]   rd_index  = word_index(s_axi_araddr);
   wire         wr_lane0  = wr_fire & w_strb[0];
   wire [7:0]   wbyte     = w_data[7:0];

   // Write target decode
   wire         wr_reload_low  = wr_lane0 && (wr_index == idx_reload_low);
   wire         wr_reload_high = wr_lane0 && (wr_index == idx_reload_high);
   wire         wr_config      = wr_lane0 && (wr_index == idx_timer_config);
   wire         wr_enable      = wr_lane0 && (wr_index == idx_irq_enable);
   wire         wr_status      = wr_lane0 && (wr_index == idx_irq_status);
   wire         wr_known;
   wire         rd_known;
   assign wr_known = (wr_index >= idx_cap0_rise) && (wr_index <= idx_irq_status);
   assign rd_known = (rd_index >= idx_cap0_rise) && (rd_index <= idx_irq_status);

   // Read mux; reserved bits read as zero
   logic [7:0]  rd_byte;
   always_comb begin
      rd_byte = byte_reset;
      if (rd_index == idx_cap0_rise) begin
         rd_byte = cap_time[src_c0_rise];
      end else if (rd_index == idx_cap1_rise) begin
         rd_byte = cap_time[src_c1_rise];
      end else if (rd_index == idx_cap0_fall) begin
         rd_byte = cap_time[src_c0_fall];
      end else if (rd_index == idx_cap1_fall) begin
         rd_byte = cap_time[src_c1_fall];
      end else if (rd_index == idx_count_low) begin
         rd_byte = count[7:0];
      end else if (rd_index == idx_count_high) begin
         rd_byte = {4'h0, count_high_hold};
      end else if (rd_index == idx_reload_low) begin
         rd_byte = reload[7:0];
      end else if (rd_index == idx_reload_high) begin
         rd_byte = {4'h0, reload[11:8]};
      end else if (rd_index == idx_timer_config) begin
         rd_byte = {timer_config[7:3], 3'h0};
      end else if (rd_index == idx_irq_enable) begin
         rd_byte = {4'h0, irq_enable};
      end else if (rd_index == idx_irq_status) begin
         rd_byte = {4'h0, irq_status};
      end
   end

   // Reads of the capture registers re-arm first-edge-hold
   wire [3:0]   cap_read;
   assign cap_read[src_c0_rise] = rd_take && (rd_index == idx_cap0_rise);
   assign cap_read[src_c0_fall] = rd_take && (rd_index == idx_cap0_fall);
   assign cap_read[src_c1_rise] = rd_take && (rd_index == idx_cap1_rise);
   assign cap_read[src_c1_fall] = rd_take && (rd_index == idx_cap1_fall);
   wire         count_low_read = rd_take && (rd_index == idx_count_low);

   // Interval timer terminal count
   wire         terminal = timer_tick && (count == 12'h000);

   // Ready: one transaction of each kind at a time
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   // Interrupt requests stay high while flag and enable are both set
   assign capture_irq = irq_status & irq_enable;

   // Pin history for edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in0_q <= 1'b0;
         in1_q <= 1'b0;
      end else begin
         in0_q <= capture_input_zero;
         in1_q <= capture_input_one;
      end
   end

   // Capture registers and their read-since-load marks, one process so each has one driver
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 4; i++) begin
            cap_time[i]       <= byte_reset;
            cap_read_since[i] <= 1'b1;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (ev.load[i]) begin
               cap_time[i]       <= src_byte[i];
               cap_read_since[i] <= 1'b0;
            end else if (cap_read[i]) begin
               cap_read_since[i] <= 1'b1;
            end
         end
      end
   end

   // Status flags: a capture load in the cycle of a clear keeps the flag set
   wire [3:0]   next_status = (irq_status & ~(wr_status ? wbyte[3:0] : 4'h0)) | ev.load;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 4'h0;
      end else begin
         irq_status <= next_status;
      end
   end

   // Software-written control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_enable   <= 4'h0;
         timer_config <= byte_reset;
         reload       <= reload_reset;
      end else begin
         if (wr_enable) irq_enable <= wbyte[3:0];
         if (wr_config) timer_config <= {wbyte[7:3], 3'h0};
         if (wr_reload_low) reload[7:0] <= wbyte;
         if (wr_reload_high) reload[11:8] <= wbyte[3:0];
      end
   end

   // Interval counter: down-count on the timer tick, reload at zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count        <= reload_reset;
         interval_irq <= 1'b0;
      end else begin
         interval_irq <= terminal;
         if (terminal) begin
            count <= reload;
         end else if (timer_tick) begin
            count <= count - 12'h001;
         end
      end
   end

   // Upper nibble snapshot taken on every low-byte read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_high_hold <= 4'h0;
      end else if (count_low_read) begin
         count_high_hold <= count[11:8];
      end
   end

   // Write address and data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response; writes to read-only registers are accepted and ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= resp_okay;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_known ? resp_okay : resp_slverr;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read response, registered so data comes from flip-flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= resp_okay;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h000000, rd_byte};
         s_axi_rresp  <= rd_known ? resp_okay : resp_slverr;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : edge_capture_and_interval_timer

// ### verif/edge_capture_assertions.sv
`timescale 1ns/1ps
module edge_capture_checker
   import edge_capture_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Pins, tick and requests
   input wire logic        timer_tick,
   input wire logic        capture_input_zero,
   input wire logic        capture_input_one,
   input wire logic [3:0]  capture_irq,
   input wire logic        interval_irq,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Transfers taken by the slave
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   // Bus answers; unmapped places get an error code, checked on reads only, so a read decode slip shows here
   property p_wr_resp;
      s_wr_taken |-> ##2 s_axi_bvalid;
   endproperty
   property p_rd_resp;
      s_rd_taken |=> s_axi_rvalid && s_axi_rresp ==
         (($past(s_axi_araddr) inside {[8'h88:8'hb3]}) ? resp_okay : resp_slverr);
   endproperty
   property p_rd_upper;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   // A request rises only on its pin edge or on a register write
   property p_rise0;
      $rose(capture_irq[0]) |->
         ($past(capture_input_zero) && !$past(capture_input_zero, 2)) || $rose(s_axi_bvalid);
   endproperty
   property p_fall0;
      $rose(capture_irq[1]) |->
         (!$past(capture_input_zero) && $past(capture_input_zero, 2)) || $rose(s_axi_bvalid);
   endproperty
   // Wide mode lets input zero stand in for input one
   property p_chan1;
      $rose(capture_irq[3]) |-> (!$past(capture_input_one) && $past(capture_input_one, 2))
         || (!$past(capture_input_zero) && $past(capture_input_zero, 2)) || $rose(s_axi_bvalid);
   endproperty
   // Requests drop only through a status or enable write
   property p_drop;
      |($past(capture_irq) & ~capture_irq) |-> $rose(s_axi_bvalid);
   endproperty
   property p_interval;
      interval_irq |-> $past(timer_tick);
   endproperty

   a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
   a_rd_resp: assert property (p_rd_resp) else $error("read answer wrong");
   a_rd_upper: assert property (p_rd_upper) else $error("upper read lanes set");
   a_rise0: assert property (p_rise0) else $error("rise request without cause");
   a_fall0: assert property (p_fall0) else $error("fall request without cause");
   a_chan1: assert property (p_chan1) else $error("channel one request odd");
   a_drop: assert property (p_drop) else $error("request dropped alone");
   a_interval: assert property (p_interval) else $error("interval pulse no tick");
endmodule : edge_capture_checker

bind edge_capture_and_interval_timer edge_capture_checker edge_capture_checker_i (
   .aclk, .aresetn, .timer_tick, .capture_input_zero, .capture_input_one, .capture_irq,
   .interval_irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

// ### verif/capture_pin_model.sv
`timescale 1ns/1ps
module capture_pin_model (
   // Clock
   input  wire logic       aclk,
   // Levels asked for by the bench
   input  wire logic [1:0] level_req,
   // Capture pins
   output logic            capture_input_zero,
   output logic            capture_input_one
);
   // Pins start low so no edge is seen when reset lets go
   initial begin
      capture_input_zero = 1'b0;
      capture_input_one  = 1'b0;
   end
   // Synchronous source: pins move just after the edge
   always @(posedge aclk) begin
      capture_input_zero <= level_req[0];
      capture_input_one  <= level_req[1];
   end
endmodule : capture_pin_model

// ### verif/test_edge_capture_and_interval_timer.sv
`timescale 1ns/1ps
module test_edge_capture_and_interval_timer;
   import edge_capture_pkg::*;
   // Clock, time base and pins
   logic        aclk          = 1'b0;
   logic        aresetn       = 1'b0;
   logic [15:0] free_timer    = 16'h0000;
   logic        timer_tick    = 1'b0;
   logic [1:0]  level_req     = 2'b00;
   logic        capture_input_zero;
   logic        capture_input_one;
   logic [3:0]  capture_irq;
   logic        interval_irq;
   // Register bus
   logic [7:0]  s_axi_awaddr  = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata   = 32'h00000000;
   logic [3:0]  s_axi_wstrb   = 4'hf;
   logic        s_axi_wvalid  = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready  = 1'b0;
   logic [7:0]  s_axi_araddr  = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready  = 1'b0;
   logic [31:0] rd_data;
   logic [1:0]  resp;
   int          num_errors    = 0;
   int          compares      = 0;
   int          irq_pulses    = 0;

   always #2.5 aclk = ~aclk;

   // Count interval request pulses so each reload is seen once
   always @(posedge aclk) begin
      if (interval_irq === 1'b1) irq_pulses++;
   end

   edge_capture_and_interval_timer edge_capture_and_interval_timer_i (.aclk, .aresetn,
      .free_timer, .timer_tick, .capture_input_zero, .capture_input_one, .capture_irq,
      .interval_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   capture_pin_model capture_pin_model_i (.aclk, .level_req, .capture_input_zero,
      .capture_input_one);

   task automatic tally_and_finish();
      if (num_errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // A wait that ran out is a failure and ends the run
   task automatic bound_wait(input logic done);
      if (done !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
   endtask : bound_wait

   // Address and data offered together, each released at the edge that takes it
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= {idx[5:0], 2'b00};
      s_axi_wdata   <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
      bound_wait(s_axi_bvalid);
   endtask : wr

   task automatic rd(input logic [7:0] idx);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr  <= {idx[5:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      bound_wait(s_axi_rvalid);
   endtask : rd

   task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
      rd(idx);
      chk(rd_data, {24'h000000, exp});
      chk({30'h0, resp}, {30'h0, resp_okay});
   endtask : rc

   // Time base held still across the pin edge, so the captured value is exact
   task automatic pin(input logic [1:0] lv, input logic [15:0] t);
      @(posedge aclk);
      free_timer <= t;
      level_req  <= lv;
      repeat (3) @(posedge aclk);
   endtask : pin

   task automatic ticks(input int n);
      @(posedge aclk);
      timer_tick <= 1'b1;
      repeat (n) @(posedge aclk);
      timer_tick <= 1'b0;
   endtask : ticks

   // Main sequence
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 34; i <= 44; i++) rc(8'(i), 8'h00);
      wr(idx_reload_low, 8'ha5);
      wr(idx_reload_high, 8'hff);
      rc(idx_reload_low, 8'ha5);
      rc(idx_reload_high, 8'h0f);
      wr(idx_irq_enable, 8'hf0);
      rc(idx_irq_enable, 8'h00);
      wr(idx_cap0_rise, 8'h55);
      chk({30'h0, resp}, {30'h0, resp_okay});
      rc(idx_cap0_rise, 8'h00);
      rd(8'h30);
      chk({30'h0, resp}, {30'h0, resp_slverr});
      wr(8'h30, 8'h01);
      chk({30'h0, resp}, {30'h0, resp_slverr});
      rc(idx_irq_status, 8'h00);
      // Eight-bit captures on both channels at every prescale code
      for (int p = 0; p < 8; p++) begin
         wr(idx_timer_config, 8'(p << 4));
         pin(2'b01, 16'hc3a5);
         pin(2'b00, 16'h3c5a);
         pin(2'b10, 16'h96e1);
         pin(2'b00, 16'h691e);
         rc(idx_cap0_rise, 8'(16'hc3a5 >> p));
         rc(idx_cap0_fall, 8'(16'h3c5a >> p));
         rc(idx_cap1_rise, 8'(16'h96e1 >> p));
         rc(idx_cap1_fall, 8'(16'h691e >> p));
      end
      rc(idx_irq_status, 8'h0f);
      wr(idx_irq_status, 8'h01);
      rc(idx_irq_status, 8'h0e);
      chk({28'h0, capture_irq}, 32'h0);
      wr(idx_irq_enable, 8'h06);
      chk({28'h0, capture_irq}, 32'h6);
      wr(idx_irq_enable, 8'h0f);
      chk({28'h0, capture_irq}, 32'he);
      wr(idx_irq_status, 8'h00);
      rc(idx_irq_status, 8'h0e);
      wr(idx_irq_status, 8'h0f);
      rc(idx_irq_status, 8'h00);
      // Wide mode: channel one ignores its pin and keeps the upper byte
      wr(idx_timer_config, 8'h08);
      pin(2'b01, 16'h9e37);
      pin(2'b00, 16'h4bd2);
      pin(2'b10, 16'h1234);
      pin(2'b00, 16'h5678);
      rc(idx_cap0_rise, 8'h37);
      rc(idx_cap1_rise, 8'h9e);
      rc(idx_cap0_fall, 8'hd2);
      rc(idx_cap1_fall, 8'h4b);
      // First-edge hold keeps the first time until a read re-arms it
      wr(idx_timer_config, 8'h80);
      rc(idx_timer_config, 8'h80);
      pin(2'b01, 16'h0011);
      pin(2'b00, 16'h0022);
      pin(2'b01, 16'h0033);
      rc(idx_cap0_rise, 8'h11);
      pin(2'b00, 16'h0044);
      pin(2'b01, 16'h0055);
      rc(idx_cap0_rise, 8'h55);
      rc(idx_cap0_fall, 8'h22);
      // Interval count: reload, count down, latched upper nibble
      wr(idx_reload_low, 8'h03);
      wr(idx_reload_high, 8'h00);
      ticks(1);
      rc(idx_count_low, 8'h03);
      ticks(2);
      wr(idx_reload_low, 8'h23);
      wr(idx_reload_high, 8'h01);
      ticks(2);
      rc(idx_count_low, 8'h23);
      ticks(36);
      rc(idx_count_high, 8'h01);
      rc(idx_count_low, 8'hff);
      rc(idx_count_high, 8'h00);
      chk(irq_pulses, 32'd2);
      tally_and_finish();
   end
endmodule : test_edge_capture_and_interval_timer
